// *** bus_cycle_params.svh ***
// offsets, encodings and cycle counts for the bus cycle sequencer
`ifndef BUS_CYCLE_PARAMS_SVH
`define BUS_CYCLE_PARAMS_SVH

`define ADDR_DUMMY  16'hffff
`define LEN_INH     3'd2
`define LEN_JUMP    3'd3
`define LEN_ACC     3'd4
`define LEN_WORD    3'd5
`define LEN_LONG    3'd6
`define RET_OFS_IDX 16'h0002
`define RET_OFS_EXT 16'h0003
`define STEP_FIRST  3'd1

`endif

// *** bus_cycle_pkg.sv ***
// types shared by the bus cycle sequencer
package bus_cycle_pkg;

    typedef enum logic [3:0] {
        K_JUMP,
        K_ACC_LOAD,
        K_ACC_STORE,
        K_WORD_LOAD,
        K_WORD_STORE,
        K_RMW,
        K_WORD_ARITH,
        K_CALL,
        K_INHERENT
    } op_kind_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } seq_state_t;

endpackage

// *** cpu_bus_cycle_sequencer.sv ***
// bus cycle sequencer for indexed, extended and short inherent instructions
`include "bus_cycle_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_cycle_sequencer
    import bus_cycle_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        start_i,
    input  wire op_kind_t    kind_i,
    input  wire logic        extended_i,
    input  wire logic [15:0] op_addr_i,
    input  wire logic [15:0] index_i,
    input  wire logic [15:0] stack_i,
    input  wire logic [15:0] store_data_i,
    input  wire logic [7:0]  new_data_i,
    input  wire logic [7:0]  data_i,
    output logic      [15:0] addr_o,
    output logic             rw_o,
    output logic      [7:0]  data_o,
    output logic             data_oe_o,
    output logic             busy_o,
    output logic             last_o,
    output logic      [2:0]  step_o,
    output logic      [7:0]  rd_data_o,
    output logic             rd_valid_o
);

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    seq_state_t  state_q;
    seq_state_t  state_d;
    logic [2:0]  step_q;
    logic [2:0]  step_d;
    logic [2:0]  len_q;
    logic [2:0]  len_d;
    logic        last_d;
    op_kind_t    kind_q;
    logic        ext_q;
    logic [15:0] op_q;
    logic [15:0] idx_q;
    logic [15:0] sp_q;
    logic [15:0] store_q;
    logic [7:0]  hi_q;
    logic [15:0] ea_q;
    logic [15:0] ea_now;
    logic [15:0] ret_addr;
    logic [15:0] addr_d;
    logic        rw_d;
    logic [7:0]  dout_d;
    logic        oe_d;
    logic        take;
    logic [2:0]  nxt;

    // reset is released through two flops so every flop on rst_n leaves reset together
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    function automatic logic [2:0] len_of(input op_kind_t k);
        unique case (k)
            K_JUMP:       len_of = `LEN_JUMP;
            K_ACC_LOAD,
            K_ACC_STORE:  len_of = `LEN_ACC;
            K_WORD_LOAD,
            K_WORD_STORE: len_of = `LEN_WORD;
            K_RMW,
            K_WORD_ARITH,
            K_CALL:       len_of = `LEN_LONG;
            default:      len_of = `LEN_INH;
        endcase
    endfunction

    // a new instruction may start in the final cycle of the previous one
    assign take = start_i && ((state_q == ST_IDLE) || last_o);
    assign nxt  = step_q + 3'd1;
    // indexed: offset is unsigned; extended: low address byte arrives this cycle
    assign ea_now   = ext_q ? {hi_q, data_i} : idx_q + {8'h00, hi_q};
    assign ret_addr = op_q + (ext_q ? `RET_OFS_EXT : `RET_OFS_IDX);

    always_comb
    begin
        state_d = ST_IDLE;
        step_d  = 3'd0;
        len_d   = len_q;
        addr_d  = `ADDR_DUMMY;
        rw_d    = 1'b1;
        dout_d  = 8'h00;
        oe_d    = 1'b0;
        if (take)
        begin
            state_d = ST_RUN;
            step_d  = `STEP_FIRST;
            len_d   = len_of(kind_i);
            addr_d  = op_addr_i;
        end
        else if (state_q == ST_RUN && !last_o)
        begin
            state_d = ST_RUN;
            step_d  = nxt;
            unique case (nxt)
                3'd2: addr_d = op_q + 16'h0001;
                3'd3: addr_d = ext_q ? op_q + 16'h0002 : `ADDR_DUMMY;
                3'd4:
                begin
                    addr_d = ea_now;
                    if (kind_q == K_ACC_STORE)
                    begin
                        rw_d   = 1'b0;
                        oe_d   = 1'b1;
                        dout_d = store_q[7:0];
                    end
                    else if (kind_q == K_WORD_STORE)
                    begin
                        rw_d   = 1'b0;
                        oe_d   = 1'b1;
                        dout_d = store_q[15:8];
                    end
                end
                3'd5:
                begin
                    unique case (kind_q)
                        K_RMW: addr_d = `ADDR_DUMMY;
                        K_CALL:
                        begin
                            addr_d = sp_q;
                            rw_d   = 1'b0;
                            oe_d   = 1'b1;
                            dout_d = ret_addr[7:0];
                        end
                        K_WORD_STORE:
                        begin
                            addr_d = ea_q + 16'h0001;
                            rw_d   = 1'b0;
                            oe_d   = 1'b1;
                            dout_d = store_q[7:0];
                        end
                        default: addr_d = ea_q + 16'h0001;
                    endcase
                end
                3'd6:
                begin
                    unique case (kind_q)
                        K_RMW:
                        begin
                            addr_d = ea_q;
                            rw_d   = 1'b0;
                            oe_d   = 1'b1;
                            dout_d = new_data_i;
                        end
                        K_CALL:
                        begin
                            // indexed call climbs, extended call descends
                            addr_d = ext_q ? sp_q - 16'h0001 : sp_q + 16'h0001;
                            rw_d   = 1'b0;
                            oe_d   = 1'b1;
                            dout_d = ret_addr[15:8];
                        end
                        default: addr_d = `ADDR_DUMMY;
                    endcase
                end
                default: addr_d = `ADDR_DUMMY;
            endcase
        end
    end

    assign last_d = (state_d == ST_RUN) && (step_d == len_d);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            step_q  <= 3'd0;
            len_q   <= `LEN_INH;
        end
        else
        begin
            state_q <= state_d;
            step_q  <= step_d;
            len_q   <= len_d;
        end
    end

    // operands are frozen at acceptance so the core may move on meanwhile
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kind_q  <= K_INHERENT;
            ext_q   <= 1'b0;
            op_q    <= 16'h0000;
            idx_q   <= 16'h0000;
            sp_q    <= 16'h0000;
            store_q <= 16'h0000;
        end
        else if (take)
        begin
            kind_q  <= kind_i;
            ext_q   <= extended_i;
            op_q    <= op_addr_i;
            idx_q   <= index_i;
            sp_q    <= stack_i;
            store_q <= store_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hi_q <= 8'h00;
            ea_q <= 16'h0000;
        end
        else if (state_q == ST_RUN && !take)
        begin
            if (step_q == 3'd2)
                hi_q <= data_i;
            if (step_q == 3'd3)
                ea_q <= ea_now;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_o    <= `ADDR_DUMMY;
            rw_o      <= 1'b1;
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
            busy_o    <= 1'b0;
            last_o    <= 1'b0;
            step_o    <= 3'd0;
        end
        else
        begin
            addr_o    <= addr_d;
            rw_o      <= rw_d;
            data_o    <= dout_d;
            data_oe_o <= oe_d;
            busy_o    <= (state_d == ST_RUN);
            last_o    <= last_d;
            step_o    <= step_d;
        end
    end

    // read data handed back one cycle after its bus cycle
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_data_o  <= data_i;
            rd_valid_o <= busy_o && rw_o;
        end
    end

    sequence prog_idx;
        (addr_o == op_q && rw_o) ##1 (addr_o == op_q + 16'h0001 && rw_o)
            ##1 (addr_o == `ADDR_DUMMY && rw_o);
    endsequence

    sequence prog_ext;
        (addr_o == op_q && rw_o) ##1 (addr_o == op_q + 16'h0001 && rw_o)
            ##1 (addr_o == op_q + 16'h0002 && rw_o);
    endsequence

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    idx_jump_a: assert property (take && kind_i == K_JUMP && !extended_i |=>
        prog_idx and (1'b1 ##2 last_o)) else $error("indexed jump sequence wrong");
    idx_acc_a: assert property (take && (kind_i == K_ACC_LOAD || kind_i == K_ACC_STORE)
        && !extended_i |=> prog_idx ##1 (addr_o == idx_q + {8'h00, hi_q} && last_o
        && rw_o == (kind_q != K_ACC_STORE))) else $error("indexed accumulator cycle wrong");
    idx_word_ld_a: assert property (take && kind_i == K_WORD_LOAD && !extended_i |=>
        prog_idx ##1 (addr_o == ea_q && rw_o) ##1 (addr_o == ea_q + 16'h0001 && rw_o && last_o))
        else $error("indexed word load wrong");
    idx_word_st_a: assert property (take && kind_i == K_WORD_STORE && !extended_i |=>
        prog_idx ##1 (!rw_o && data_o == store_q[15:8])
        ##1 (!rw_o && data_o == store_q[7:0] && last_o)) else $error("indexed word store wrong");
    idx_rmw_a: assert property (take && kind_i == K_RMW && !extended_i |=> prog_idx
        ##1 (addr_o == ea_q && rw_o) ##1 (addr_o == `ADDR_DUMMY && rw_o)
        ##1 (addr_o == ea_q && !rw_o && last_o)) else $error("indexed rmw wrong");
    idx_arith_a: assert property (take && kind_i == K_WORD_ARITH && !extended_i |=>
        prog_idx ##1 rw_o [*2] ##1 (addr_o == `ADDR_DUMMY && rw_o && last_o))
        else $error("indexed word arith wrong");
    idx_call_a: assert property (take && kind_i == K_CALL && !extended_i |=> prog_idx
        ##1 (addr_o == ea_q && rw_o) ##1 (addr_o == sp_q && !rw_o)
        ##1 (addr_o == sp_q + 16'h0001 && !rw_o && last_o)) else $error("indexed call wrong");
    ext_jump_a: assert property (take && kind_i == K_JUMP && extended_i |=>
        prog_ext and (1'b1 ##2 last_o)) else $error("extended jump wrong");
    ext_acc_ld_a: assert property (take && kind_i == K_ACC_LOAD && extended_i |=>
        prog_ext ##1 (addr_o == ea_q && rw_o && last_o)) else $error("extended load wrong");
    ext_acc_st_a: assert property (take && kind_i == K_ACC_STORE && extended_i |=>
        prog_ext ##1 (!rw_o && data_oe_o && data_o == store_q[7:0] && last_o))
        else $error("extended accumulator store wrong");
    ext_word_ld_a: assert property (take && kind_i == K_WORD_LOAD && extended_i |=>
        prog_ext ##1 rw_o ##1 (addr_o == ea_q + 16'h0001 && rw_o && last_o))
        else $error("extended word load wrong");
    ext_word_st_a: assert property (take && kind_i == K_WORD_STORE && extended_i |=>
        prog_ext ##1 (addr_o == ea_q && !rw_o && data_o == store_q[15:8])
        ##1 (!rw_o && data_o == store_q[7:0] && last_o)) else $error("extended word store wrong");
    ext_rmw_a: assert property (take && kind_i == K_RMW && extended_i |=> prog_ext
        ##1 rw_o ##1 (addr_o == `ADDR_DUMMY) ##1 (addr_o == ea_q && !rw_o && last_o))
        else $error("extended rmw wrong");
    ext_arith_a: assert property (take && kind_i == K_WORD_ARITH && extended_i |=>
        prog_ext ##1 rw_o [*2] ##1 (addr_o == `ADDR_DUMMY && rw_o && last_o))
        else $error("extended word arith wrong");
    ext_call_a: assert property (take && kind_i == K_CALL && extended_i |=> prog_ext
        ##1 rw_o ##1 (addr_o == sp_q && data_o == ret_addr[7:0] && !rw_o)
        ##1 (addr_o == sp_q - 16'h0001 && !rw_o && last_o)) else $error("extended call wrong");
    inh_short_a: assert property (take && kind_i == K_INHERENT |=>
        (addr_o == op_q && rw_o) ##1 (addr_o == op_q + 16'h0001 && rw_o && last_o))
        else $error("inherent sequence wrong");

endmodule

`default_nettype wire

// *** bus_memory_model.sv ***
// system bus memory model facing the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none

module bus_memory_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        rw_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_en_i,
    output logic      [7:0]  rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    initial
    begin
        for (int a = 0; a < 65536; a++)
            mem[a] = a[15:8] ^ a[7:0] ^ 8'h5a;
    end

    always @(posedge clk_i)
    begin
        if (!rw_i && wr_en_i)
            mem[addr_i] <= wdata_i;
        last_q <= rdata_o;
    end

    // bus not driven by memory in write cycles: show the inverse, not a stale copy
    always_comb rdata_o = rw_i ? mem[addr_i] : ~last_q;
endmodule

`default_nettype wire

// *** tb_cpu_bus_cycle_sequencer.sv ***
// self-checking testbench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_bus_cycle_sequencer
    import bus_cycle_pkg::*;
;
    localparam logic [15:0] IDX = 16'h4000;
    localparam logic [15:0] SP  = 16'h0180;
    localparam logic [15:0] ST  = 16'hc3a5;
    localparam logic [7:0]  ND  = 8'h96;

    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        start = 1'b0;
    op_kind_t    kind = K_INHERENT;
    logic        ext = 1'b0;
    logic [15:0] op_addr = 16'h0000;
    logic [15:0] index_v = IDX;
    logic [15:0] stack_v = SP;
    logic [15:0] store_v = ST;
    op_kind_t    pend_k = K_INHERENT;
    logic        pend_x = 1'b0;
    logic [15:0] pend_op = 16'h0000;
    logic [15:0] addr;
    logic        rw;
    logic        oe;
    logic        busy;
    logic        last;
    logic        rd_valid;
    logic [7:0]  wdata;
    logic [7:0]  rd_data;
    logic [7:0]  mem_data;
    logic [2:0]  step;
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [15:0] ea [1:6];
    logic        er [1:6];
    logic [7:0]  ed [1:6];
    int          len;

    cpu_bus_cycle_sequencer u_cpu_bus_cycle_sequencer (
        .clk_i(clk), .reset_n_i(reset_n), .start_i(start), .kind_i(kind),
        .extended_i(ext), .op_addr_i(op_addr), .index_i(index_v), .stack_i(stack_v),
        .store_data_i(store_v), .new_data_i(ND), .data_i(mem_data), .addr_o(addr),
        .rw_o(rw), .data_o(wdata), .data_oe_o(oe), .busy_o(busy), .last_o(last),
        .step_o(step), .rd_data_o(rd_data), .rd_valid_o(rd_valid)
    );

    bus_memory_model u_bus_memory_model (
        .clk_i(clk), .addr_i(addr), .rw_i(rw), .wdata_i(wdata), .wr_en_i(oe),
        .rdata_o(mem_data)
    );

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ceiling well above the roughly 145 cycles the sequence needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            err_count++;
            summarize();
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] pat(logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5a;
    endfunction

    function automatic void build(op_kind_t k, logic x, logic [15:0] op);
        logic [15:0] oa;
        logic [15:0] ret;
        oa = x ? {pat(op + 16'h0001), pat(op + 16'h0002)} : IDX + {8'h00, pat(op + 16'h0001)};
        ret = op + (x ? 16'h0003 : 16'h0002);
        for (int n = 1; n <= 6; n++)
        begin
            er[n] = 1'b1;
            ed[n] = 8'h00;
        end
        ea[1] = op;
        ea[2] = op + 16'h0001;
        ea[3] = x ? op + 16'h0002 : 16'hffff;
        ea[4] = oa;
        ea[5] = oa + 16'h0001;
        ea[6] = 16'hffff;
        case (k)
            K_JUMP: len = 3;
            K_ACC_LOAD: len = 4;
            K_ACC_STORE:
            begin
                len = 4;
                er[4] = 1'b0;
                ed[4] = ST[7:0];
            end
            K_WORD_LOAD: len = 5;
            K_WORD_STORE:
            begin
                len = 5;
                {er[4], er[5], ed[4], ed[5]} = {2'b00, ST};
            end
            K_RMW:
            begin
                len = 6;
                {ea[5], ea[6], er[6], ed[6]} = {16'hffff, oa, 1'b0, ND};
            end
            K_WORD_ARITH: len = 6;
            K_CALL:
            begin
                len = 6;
                ea[5] = SP;
                // indexed call places the high byte above, extended below
                ea[6] = x ? SP - 16'h0001 : SP + 16'h0001;
                {er[5], er[6], ed[5], ed[6]} = {2'b00, ret[7:0], ret[15:8]};
            end
            default: len = 2;
        endcase
    endfunction

    // called at a rising edge; expectations are built when the walk starts
    task automatic prep(op_kind_t k, logic x, logic [15:0] op);
        pend_k = k;
        pend_x = x;
        pend_op = op;
        kind <= k;
        ext <= x;
        op_addr <= op;
        index_v <= IDX;
        stack_v <= SP;
        store_v <= ST;
        start <= 1'b1;
    endtask

    task automatic walk(input logic refuse, input logic chain, input op_kind_t nk,
                        input logic nx, input logic [15:0] nop, output int bad);
        logic [7:0] prev;
        bad = 0;
        prev = 8'h00;
        build(pend_k, pend_x, pend_op);
        for (int k = 1; k <= len; k++)
        begin
            @(posedge clk);
            if (k == 1)
            begin
                start <= 1'b0;
                // operands must be frozen at acceptance, not followed live
                index_v <= ~IDX;
                stack_v <= ~SP;
                store_v <= ~ST;
            end
            // a request raised mid-instruction must leave the sequence untouched
            if (refuse && (k == 2 || k == 4))
            begin
                start <= (k == 2);
                op_addr <= op_addr ^ 16'h0800;
            end
            // back to back: next request stands while this one shows last
            if (chain && k == len)
                prep(nk, nx, nop);
            #1;
            if (addr !== ea[k] || rw !== er[k] || oe !== !er[k] || step !== 3'(k)
                || busy !== 1'b1 || last !== (k == len) || (!er[k] && wdata !== ed[k])
                || (k > 1 && er[k-1] && (rd_valid !== 1'b1 || rd_data !== prev)))
            begin
                bad++;
                $display("cycle %0d addr %0h rw %b data %0h", k, addr, rw, wdata);
            end
            prev = mem_data;
        end
        if (!chain)
        begin
            @(posedge clk);
            #1;
            if (addr !== 16'hffff || busy !== 1'b0 || rw !== 1'b1 || oe !== 1'b0)
                bad++;
        end
    endtask

    task automatic one(op_kind_t k, logic x, logic [15:0] op, logic rf, output int bad);
        @(posedge clk);
        prep(k, x, op);
        walk(rf, 1'b0, K_INHERENT, 1'b0, 16'h0000, bad);
    endtask

    task automatic t_jumps();
        int b;
        one(K_JUMP, 1'b0, 16'h1000, 1'b0, b);
        check("idx_jump", b, 0);
        one(K_JUMP, 1'b1, 16'h2000, 1'b0, b);
        check("ext_jump", b, 0);
    endtask

    task automatic t_acc();
        int b;
        one(K_ACC_LOAD, 1'b0, 16'h1010, 1'b0, b);
        check("idx_acc_load", b, 0);
        one(K_ACC_STORE, 1'b0, 16'h1020, 1'b0, b);
        check("idx_acc_store", b, 0);
        one(K_ACC_LOAD, 1'b1, 16'h2010, 1'b0, b);
        check("ext_acc_load", b, 0);
        one(K_ACC_STORE, 1'b1, 16'h2020, 1'b0, b);
        check("ext_acc_store", b, 0);
    endtask

    task automatic t_words();
        int b;
        one(K_WORD_LOAD, 1'b0, 16'h1030, 1'b0, b);
        check("idx_word_load", b, 0);
        one(K_WORD_STORE, 1'b0, 16'h1040, 1'b0, b);
        check("idx_word_store", b, 0);
        one(K_WORD_LOAD, 1'b1, 16'h2030, 1'b0, b);
        check("ext_word_load", b, 0);
        one(K_WORD_STORE, 1'b1, 16'h2040, 1'b0, b);
        check("ext_word_store", b, 0);
    endtask

    task automatic t_long();
        int b;
        one(K_RMW, 1'b0, 16'h1050, 1'b0, b);
        check("idx_rmw", b, 0);
        one(K_RMW, 1'b1, 16'h2050, 1'b0, b);
        check("ext_rmw", b, 0);
        one(K_WORD_ARITH, 1'b0, 16'h1060, 1'b0, b);
        check("idx_arith", b, 0);
        one(K_WORD_ARITH, 1'b1, 16'h2060, 1'b0, b);
        check("ext_arith", b, 0);
        one(K_CALL, 1'b0, 16'h1070, 1'b1, b);
        check("idx_call", b, 0);
        one(K_CALL, 1'b1, 16'h2070, 1'b1, b);
        check("ext_call", b, 0);
    endtask

    task automatic t_chain();
        int b;
        @(posedge clk);
        prep(K_INHERENT, 1'b0, 16'h1080);
        walk(1'b0, 1'b1, K_INHERENT, 1'b1, 16'h1082, b);
        check("inherent_a", b, 0);
        walk(1'b0, 1'b1, K_WORD_STORE, 1'b1, 16'h2080, b);
        check("inherent_b", b, 0);
        walk(1'b0, 1'b0, K_INHERENT, 1'b0, 16'h0000, b);
        check("chained_store", b, 0);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        check("reset_bus", {addr, rw, oe, busy, step}, {16'hffff, 1'b1, 1'b0, 1'b0, 3'd0});
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_jumps();
        t_acc();
        t_words();
        t_long();
        t_chain();
        summarize();
    end
endmodule

`default_nettype wire
